// ### src/asb_pkg.sv
// asb_pkg: constants for the host-side controller of an asynchronous static ram
// assumes a 40 MHz system clock; pin timing figures are held in ns and turned into cycles
package asb_pkg;
  // clock rate in kHz, so cycle counts stay integral
  localparam int unsigned CLK_KHZ          = 40000;
  // power-up wait in microseconds before the first access
  localparam int unsigned POWERUP_US       = 200;
  // least cycles for that wait, rounded up
  localparam int unsigned POWERUP_CYC      = (POWERUP_US * CLK_KHZ + 999) / 1000;
  // least read cycle and least write strobe in ns
  localparam int unsigned READ_CYCLE_NS    = 55;
  localparam int unsigned WRITE_PULSE_NS   = 40;
  // least cycles, rounded up, never below one
  localparam int unsigned READ_CYC         = (READ_CYCLE_NS * CLK_KHZ + 999999) / 1000000;
  localparam int unsigned WRITE_CYC        = (WRITE_PULSE_NS * CLK_KHZ + 999999) / 1000000;
  // widths of the counter, address and data
  localparam int unsigned CNT_W            = 14;
  localparam int unsigned ADDR_W           = 22;
  localparam int unsigned DATA_W           = 16;
  // values after reset
  localparam logic [DATA_W-1:0] DATA_RST   = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST   = 22'h000000;
  localparam logic [CNT_W-1:0]  CNT_RST    = 14'h0000;

  // controller states, one-hot
  typedef enum logic [4:0] {
    ASB_POWERUP = 5'b00001,  // waiting out the power-up time
    ASB_IDLE    = 5'b00010,  // deselected, ready for a request
    ASB_SETUP   = 5'b00100,  // address and lanes set, strobe not yet asserted
    ASB_ACTIVE  = 5'b01000,  // strobe or output drive asserted
    ASB_DONE    = 5'b10000   // strobe released, answer presented
  } asb_state_t;
endpackage : asb_pkg

// ### src/asb_ctrl.sv
// asb_ctrl: host controller driving an asynchronous static ram through its pins
// assumes the sram pins are wired straight to the ports; data pins are split in/out/enable
// and the wire level is resolved outside; the width strap is fixed while out of reset
`timescale 1ns/1ps
`default_nettype none

// Function
// - write: primary low, secondary high, strobe low
// - read: selects on, drive low, strobe high
// - width strap picks word or byte mode
// - host waits 200 us after power-up
// - write spans overlap of all enables
module asb_ctrl
  import asb_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES = POWERUP_CYC  // shorten in simulation
) (
  // clock and reset
  input  wire  logic              clock_in,
  input  wire  logic              rstn_in,
  // width strap: high word-wide, low byte-wide
  input  wire  logic              word_mode_in,
  // user request
  input  wire  logic              req_valid_in,
  input  wire  logic              req_write_in,
  input  wire  logic [ADDR_W-1:0] req_addr_in,
  input  wire  logic [DATA_W-1:0] req_wdata_in,
  input  wire  logic [1:0]        req_lanes_in,
  output var   logic              req_ready_out,
  output var   logic              rsp_valid_out,
  output var   logic [DATA_W-1:0] rsp_rdata_out,
  // sram pins
  output var   logic [ADDR_W-2:0] sram_addr_out,
  output var   logic              primary_select_n_out,
  output var   logic              secondary_select_out,
  output var   logic              write_strobe_n_out,
  output var   logic              output_drive_n_out,
  output var   logic              upper_lane_select_n_out,
  output var   logic              lower_lane_select_n_out,
  input  wire  logic [DATA_W-1:0] sram_data_in,
  output var   logic [DATA_W-1:0] sram_data_out,
  output var   logic [DATA_W-1:0] sram_data_oe_out
);

  // last counter values for the access phases and the power-up wait, cut to the counter width
  localparam logic [CNT_W-1:0] RD_LAST = CNT_W'(READ_CYC - 1);
  localparam logic [CNT_W-1:0] WR_LAST = CNT_W'(WRITE_CYC - 1);
  localparam logic [CNT_W-1:0] PU_LAST = CNT_W'(POWERUP_CYCLES - 1);

  // whole state of the controller
  typedef struct packed {
    asb_state_t        st;        // phase of the access
    logic [CNT_W-1:0]  cnt;       // phase timer
    logic              wr;        // current access is a write
    logic              word;      // width strap caught after reset
    logic              rdy;       // ready for a request
    logic              rvld;      // answer pulse
    logic [DATA_W-1:0] rdata;     // answer data
    logic [ADDR_W-2:0] addr;      // address pins
    logic              sel_n;     // primary select
    logic              sel2;      // secondary select
    logic              we_n;      // write strobe
    logic              oe_n;      // output drive control
    logic              ub_n;      // upper lane select
    logic              lb_n;      // lower lane select
    logic [DATA_W-1:0] dout;      // data driven onto the pins
    logic [DATA_W-1:0] doe;       // per-bit drive enable
  } asb_ctrl_t;

  asb_ctrl_t cur;       // registered state
  asb_ctrl_t next_cur;  // next state

  // two-flop synchronisers for the pin inputs
  logic [DATA_W-1:0] data_meta;  // first stage, read only by second
  logic [DATA_W-1:0] data_sync;  // safe sampled data
  logic              strap_meta; // first stage of strap
  logic              strap_sync; // safe strap

  // synchronise the asynchronous returns
  always_ff @(posedge clock_in) begin
    data_meta  <= sram_data_in;
    data_sync  <= data_meta;
    strap_meta <= word_mode_in;
    strap_sync <= strap_meta;
  end

  // lane selects from a request; byte mode leaves lanes unused (held inactive high is wrong,
  // both high deselects), so byte mode asserts both lanes low which the device ignores
  function automatic logic [1:0] lane_n(input logic word, input logic [1:0] lanes);
    lane_n = word ? ~lanes : 2'b00;
  endfunction : lane_n

  // next-state logic
  always_comb begin
    next_cur      = cur;
    next_cur.rvld = 1'b0;
    unique case (cur.st)
      ASB_POWERUP: begin
        // hold everything deselected until the supply has settled
        if (cur.cnt == PU_LAST) begin
          next_cur.st   = ASB_IDLE;
          next_cur.rdy  = 1'b1;
          next_cur.word = strap_sync;
          next_cur.cnt  = CNT_RST;
        end else begin
          next_cur.cnt = cur.cnt + 1'b1;
        end
      end
      ASB_IDLE: begin
        if (req_valid_in) begin
          // set address and lanes first so the enables overlap a settled address
          next_cur.rdy  = 1'b0;
          next_cur.wr   = req_write_in;
          next_cur.sel_n = 1'b0;
          next_cur.sel2  = 1'b1;
          {next_cur.ub_n, next_cur.lb_n} = lane_n(cur.word, req_lanes_in);
          if (cur.word) begin
            next_cur.addr = req_addr_in[ADDR_W-2:0];
            next_cur.dout = req_wdata_in;
          end else begin
            // byte mode: lowest address bit rides on the top data line
            next_cur.addr = req_addr_in[ADDR_W-1:1];
            next_cur.dout = {req_addr_in[0], 7'h00, req_wdata_in[7:0]};
          end
          // top line drives as address in byte mode for reads as well
          next_cur.doe  = req_write_in ? (cur.word ? 16'hffff : 16'h80ff)
                        : (cur.word ? 16'h0000 : 16'h8000);
          next_cur.st   = ASB_SETUP;
        end
      end
      ASB_SETUP: begin
        // assert the strobe only once address and lanes are stable
        if (cur.wr) begin
          next_cur.we_n = 1'b0;
        end else begin
          next_cur.oe_n = 1'b0;
        end
        next_cur.cnt = CNT_RST;
        next_cur.st  = ASB_ACTIVE;
      end
      ASB_ACTIVE: begin
        // address and lanes are frozen during the overlap
        if (cur.cnt == (cur.wr ? WR_LAST : RD_LAST) + 2'd2) begin
          next_cur.we_n = 1'b1;  // write ends as the strobe rises
          next_cur.oe_n = 1'b1;
          if (!cur.wr) begin
            // synchroniser delay is covered by the two extra cycles
            next_cur.rdata = cur.word ? data_sync : {8'h00, data_sync[7:0]};
          end
          next_cur.st = ASB_DONE;
        end else begin
          next_cur.cnt = cur.cnt + 1'b1;
        end
      end
      ASB_DONE: begin
        // deselect and release the bus; device returns to standby
        next_cur.sel_n = 1'b1;
        next_cur.sel2  = 1'b0;
        next_cur.ub_n  = 1'b1;
        next_cur.lb_n  = 1'b1;
        next_cur.doe   = 16'h0000;
        next_cur.rvld  = 1'b1;
        next_cur.rdy   = 1'b1;
        next_cur.st    = ASB_IDLE;
      end
      default: begin
        next_cur.st = ASB_POWERUP;
      end
    endcase
  end

  // state register with synchronous reset
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      cur       <= '0;
      cur.st    <= ASB_POWERUP;
      cur.sel_n <= 1'b1;
      cur.we_n  <= 1'b1;
      cur.oe_n  <= 1'b1;
      cur.ub_n  <= 1'b1;
      cur.lb_n  <= 1'b1;
      cur.word  <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from the state register
  assign req_ready_out           = cur.rdy;
  assign rsp_valid_out           = cur.rvld;
  assign rsp_rdata_out           = cur.rdata;
  assign sram_addr_out           = cur.addr;
  assign primary_select_n_out    = cur.sel_n;
  assign secondary_select_out    = cur.sel2;
  assign write_strobe_n_out      = cur.we_n;
  assign output_drive_n_out      = cur.oe_n;
  assign upper_lane_select_n_out = cur.ub_n;
  assign lower_lane_select_n_out = cur.lb_n;
  assign sram_data_out           = cur.dout;
  assign sram_data_oe_out        = cur.doe;

  // host never drives the lower data lines while the device may drive them
  AST_NO_CLASH: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !cur.oe_n |-> (cur.doe[7:0] == 8'h00))
    else $error("host drives data during read");
  // write strobe only while both selects are active
  AST_WR_SEL: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !cur.we_n |-> (!cur.sel_n && cur.sel2 && cur.oe_n))
    else $error("write strobe without selects");
  // read drive only with strobe high and selects on
  AST_RD_SEL: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !cur.oe_n |-> (cur.we_n && !cur.sel_n && cur.sel2))
    else $error("read without selects");
  // address and lanes stable throughout the write overlap
  AST_WR_STABLE: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (!cur.we_n && !$past(cur.we_n)) |-> ($stable(cur.addr) && $stable({cur.ub_n, cur.lb_n})))
    else $error("address moved during write");
  // strobe pulse lasts the full least width
  AST_WR_WIDTH: assert property (@(posedge clock_in) disable iff (!rstn_in)
    $fell(cur.we_n) |-> !cur.we_n[*2])
    else $error("write pulse too short");
  // write data on the pins while the strobe is low
  AST_WR_DATA: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !cur.we_n |-> (cur.doe[7:0] == 8'hff))
    else $error("write data not driven");
  // word-mode upper byte driven while writing it
  AST_WR_HI: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (!cur.we_n && cur.word && !cur.ub_n) |-> (cur.doe[15:8] == 8'hff))
    else $error("upper byte not driven");
  // no access before the power-up wait
  AST_PWRUP: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (cur.st == ASB_POWERUP) |-> (cur.sel_n && !cur.rdy))
    else $error("access during power-up");
  // each accepted request answers within a bounded time
  AST_ANSWER: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (cur.rdy && req_valid_in) |-> ##[3:12] cur.rvld)
    else $error("no answer");
  // back in idle the device is deselected
  AST_IDLE_DESEL: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (cur.st == ASB_IDLE) |-> (cur.sel_n && !cur.sel2 && cur.doe == 16'h0000))
    else $error("idle not deselected");

  // main scenarios
  COV_WRITE: cover property (@(posedge clock_in) disable iff (!rstn_in) $rose(cur.we_n));
  COV_READ:  cover property (@(posedge clock_in) disable iff (!rstn_in) cur.rvld && !cur.wr);
  COV_BYTE:  cover property (@(posedge clock_in) disable iff (!rstn_in) !cur.word && cur.rvld);

endmodule : asb_ctrl

`default_nettype wire

// ### dv/asb_sram_model.sv
// asb_sram_model: behavioural asynchronous static ram standing at the pins
// assumes the bench resolves the shared data wire and feeds it to data_in
`timescale 1ns/1ps
`default_nettype none
module asb_sram_model
  import asb_pkg::*;
(
  // control pins from the host, and the width strap
  input  wire logic [ADDR_W-2:0] addr_in,
  input  wire logic              primary_select_n_in,
  input  wire logic              secondary_select_in,
  input  wire logic              write_strobe_n_in,
  input  wire logic              output_drive_n_in,
  input  wire logic              upper_lane_select_n_in,
  input  wire logic              lower_lane_select_n_in,
  input  wire logic              word_mode_in,
  // data wire and our drive of it
  input  wire logic [DATA_W-1:0] data_in,
  output var  logic [DATA_W-1:0] data_out,
  output var  logic [DATA_W-1:0] data_oe_out
);
  logic [15:0] wmem [logic [ADDR_W-2:0]];  // word-wide store
  logic [7:0]  bmem [logic [ADDR_W-1:0]];  // byte-wide store
  wire  [ADDR_W-1:0] baddr = {addr_in, data_in[15]};  // top data line as address
  wire  word = word_mode_in;  // strap picks organisation
  wire  lanes = !(upper_lane_select_n_in && lower_lane_select_n_in);
  // deselected, or no lane in word mode, means standby: nothing happens
  wire  sel = !primary_select_n_in && secondary_select_in && (lanes || !word);
  wire  wr = sel && !write_strobe_n_in;  // write lasts for the overlap
  wire  rd = sel && write_strobe_n_in && !output_drive_n_in;
  // stores are sparse, only written locations are kept, so idle addresses cost nothing
  // store when the overlap ends; data must still be held then
  always @(negedge wr) begin
    if (!$isunknown(addr_in)) begin
      if (word) begin
        if (!wmem.exists(addr_in)) wmem[addr_in] = 16'h0000;
        if (!lower_lane_select_n_in) wmem[addr_in][7:0] = data_in[7:0];
        if (!upper_lane_select_n_in) wmem[addr_in][15:8] = data_in[15:8];
      end else begin
        bmem[baddr] = data_in[7:0];  // lanes ignored
      end
    end
  end
  // read data follows the address, and is looked up again as a read starts, so that a
  // location written while the address stood still is not missed
  always @(addr_in, baddr, word, rd) begin
    if (word) data_out = wmem.exists(addr_in) ? wmem[addr_in] : 16'h0000;
    else data_out = {8'h00, bmem.exists(baddr) ? bmem[baddr] : 8'h00};
  end
  // while reading drive selected lanes in word mode, the lower byte in byte mode; float otherwise
  assign data_oe_out = !rd ? 16'h0000 : word ?
    {{8{!upper_lane_select_n_in}}, {8{!lower_lane_select_n_in}}} : 16'h00ff;
endmodule : asb_sram_model
`default_nettype wire

// ### dv/async_sram_byte_access_test.sv
// async_sram_byte_access_test: self-checking bench for asb_ctrl with a ram model
// assumes the controller contract: one request at a time, rsp_valid per access
`timescale 1ns/1ps
`default_nettype none
module async_sram_byte_access_test;
  import asb_pkg::*;
  logic clock_in = 0, rstn_in = 0, word_mode_in = 1;
  logic req_valid_in = 0, req_write_in = 0, req_ready_out, rsp_valid_out;
  logic [ADDR_W-1:0] req_addr_in = '0;
  logic [DATA_W-1:0] req_wdata_in = '0, rsp_rdata_out, d_in, c_out, c_oe, m_out, m_oe;
  logic [DATA_W-1:0] flt = 16'h5a5a;  // floating bits change every cycle
  logic [1:0] req_lanes_in = 2'b11;
  logic [ADDR_W-2:0] a_pin;
  logic cs_n, cs2, we_n, oe_n, ul_n, ll_n;
  logic [16:0] q[$];  // expected notes: bit16 marks a read
  logic [15:0] d [4];
  int failures = 0, checked = 0, seed = 32'h4aa9, i;
  always #12.5 clock_in = ~clock_in;
  always @(posedge clock_in) flt <= ~flt;
  // resolve the wire from both parties' enables
  assign d_in = (c_out & c_oe) | (m_out & m_oe & ~c_oe) | (flt & ~c_oe & ~m_oe);
  asb_ctrl #(.POWERUP_CYCLES(4)) dut_u (.clock_in(clock_in), .rstn_in(rstn_in),
    .word_mode_in(word_mode_in), .req_valid_in(req_valid_in), .req_write_in(req_write_in),
    .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in), .req_lanes_in(req_lanes_in),
    .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
    .rsp_rdata_out(rsp_rdata_out), .sram_addr_out(a_pin), .primary_select_n_out(cs_n),
    .secondary_select_out(cs2), .write_strobe_n_out(we_n), .output_drive_n_out(oe_n),
    .upper_lane_select_n_out(ul_n), .lower_lane_select_n_out(ll_n), .sram_data_in(d_in),
    .sram_data_out(c_out), .sram_data_oe_out(c_oe));
  asb_sram_model ram_u (.addr_in(a_pin), .primary_select_n_in(cs_n),
    .secondary_select_in(cs2), .write_strobe_n_in(we_n), .output_drive_n_in(oe_n),
    .upper_lane_select_n_in(ul_n), .lower_lane_select_n_in(ll_n),
    .word_mode_in(word_mode_in), .data_in(d_in), .data_out(m_out), .data_oe_out(m_oe));
  // compare one value and count it
  task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // verdict
  task test_done;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // reset, strap caught when the power-up wait ends
  task do_reset(input logic wm);
    rstn_in <= 0;
    req_valid_in <= 0;
    word_mode_in <= wm;
    repeat (16) @(posedge clock_in);
    rstn_in <= 1;
    @(posedge clock_in);
    check("select_n", {15'h0, cs_n}, 16'h0001);  // deselected after reset
  endtask : do_reset
  // one request; valid stays up so back-to-back requests need no gap
  task op(input logic w, input logic [21:0] a, input logic [15:0] wd,
          input logic [1:0] ln, input logic [15:0] exp);
    int n;
    n = 0;
    req_valid_in <= 1;
    req_write_in <= w;
    req_addr_in <= a;
    req_wdata_in <= wd;
    req_lanes_in <= ln;
    do begin
      @(posedge clock_in);
      n++;
    end while (req_ready_out !== 1'b1 && n < 200);
    if (n >= 200) check("ready", 16'h0, 16'h1);
    q.push_back({!w, exp});
  endtask : op
  // watcher: every response takes the oldest note
  always @(posedge clock_in) begin
    if (rsp_valid_out === 1'b1) begin
      if (q.size() == 0) check("spare_rsp", 16'h1, 16'h0);
      else if (q[0][16]) check("rdata", rsp_rdata_out, q[0][15:0]);
      if (q.size() != 0) void'(q.pop_front());
    end
  end
  initial begin
    repeat (4000) @(posedge clock_in);
    failures++;
    test_done;
  end
  initial begin
    do_reset(1);
    for (i = 0; i < 4; i++) begin
      d[i] = $random(seed);
      op(1, 22'h155550 + i, d[i], 2'b11, 0);
    end
    for (i = 0; i < 4; i++) op(0, 22'h155550 + i, 0, 2'b11, d[i]);
    // single-lane writes merge into one word
    op(1, 22'h1fffff, 16'h1122, 2'b01, 0);
    op(1, 22'h1fffff, 16'h3344, 2'b10, 0);
    op(0, 22'h1fffff, 0, 2'b11, 16'h3322);
    // no lane enabled: the device stays in standby and the word is untouched
    op(1, 22'h1fffff, 16'hffff, 2'b00, 0);
    op(0, 22'h1fffff, 0, 2'b11, 16'h3322);
    // a request withdrawn while busy must not be taken
    op(1, 22'h000001, 16'hbeef, 2'b11, 0);
    req_addr_in <= 22'h155550;
    req_wdata_in <= 16'hdead;
    repeat (3) @(posedge clock_in);
    req_valid_in <= 0;
    repeat (8) @(posedge clock_in);
    op(0, 22'h155550, 0, 2'b11, d[0]);
    op(0, 22'h000001, 0, 2'b11, 16'hbeef);
    // drop valid so the last read is not taken a second time before the reset
    req_valid_in <= 0;
    repeat (12) @(posedge clock_in);
    // byte-wide organisation: bit0 travels on the top data line
    do_reset(0);
    op(1, 22'h2aaaab, 16'hff5c, 2'b00, 0);
    op(1, 22'h2aaaaa, 16'h00a3, 2'b11, 0);
    op(0, 22'h2aaaab, 0, 2'b00, 16'h005c);
    op(0, 22'h2aaaaa, 0, 2'b11, 16'h00a3);
    req_valid_in <= 0;
    repeat (12) @(posedge clock_in);
    check("pending", 16'(q.size()), 16'h0);
    test_done;
  end
endmodule : async_sram_byte_access_test
`default_nettype wire
